//--- logic/ibq_filter_top.sv
`timescale 1ns/10ps
// Overview of operation
// - cascade of up to seven biquad sections per sample
// - five coefficients A..E per section, F scales the final output
// - coefficient is a doubling flag plus signed 12-bit base
// - slot holds flag in bit 15, base below, three zero bits
// - 28-bit datapath, base times sample, truncated divide by 4096, accumulate
// - saturate accumulator to 2^27-1 or -2^27 after each add
// - doubling flag set adds the same product a second time
// - 16-bit input samples and 16-bit output samples
// - loading-mode flag at one selects coefficient loading mode
// - ram select 00 tx, 01 second, 10 third, 11 none
// - register select picks control register for 8-bit data, 111 none
// - strobe rising with ram select starts load, slots two and three
// - clock select one picks the first clock input as master
// - sample rate register written from the frame data field
// - bit clock register written from the frame data field
// - compensation register written from the frame data field
// - high serial mode pin selects dual serial port
// - high frame rate pin sets bit frame ratio 160
module ibq_filter_top (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// frame from host
	input  wire logic        i_frame_valid,
	input  wire logic [15:0] i_tx_control_slot,
	input  wire logic [15:0] i_tx_slot_one,
	input  wire logic [15:0] i_tx_slot_two,
	input  wire logic [15:0] i_tx_slot_three,
	output logic             o_frame_ready,
	// strap pins
	input  wire logic        i_serial_mode_pin,
	input  wire logic        i_frame_rate_pin,
	// filtered samples
	output logic [15:0]      o_out_data,
	output logic             o_out_valid,
	input  wire logic        i_out_ready,
	// configuration and status
	output logic             o_coef_load_mode_flag,
	output logic             o_master_clock_select,
	output logic [7:0]       o_tx_bitclock_reg,
	output logic [7:0]       o_tx_samplerate_reg,
	output logic [7:0]       o_tx_atten_reg,
	output logic [7:0]       o_tx_compensation_reg,
	output logic             o_dual_serial_mode,
	output logic [7:0]       o_frame_ratio,
	output logic             o_load_active,
	output logic [2:0]       o_ram_loaded
);
	ibq_pkg::ibq_state_t st_r, st_nxt;
	logic [2:0]  sec_r, sec_nxt, step_r, step_nxt;
	logic [1:0]  ld_ram_r, ld_ram_nxt, wslot_r, wslot_nxt;
	logic [5:0]  ld_cnt_r, ld_cnt_nxt;
	logic [3:0]  clr_r, clr_nxt;
	logic        stb_prev_r, stb_prev_nxt;
	logic [15:0] s1_r, s1_nxt, s2_r, s2_nxt, s3_r, s3_nxt;
	logic signed [27:0] xin_r, xin_nxt, w0_r, w0_nxt, w1_r, w1_nxt, w2_r, w2_nxt;
	logic signed [27:0] acc_r, acc_nxt, p_r, p_nxt, opnd, p_now;
	logic signed [39:0] prod;
	logic signed [28:0] sum;
	logic [2:0]  loaded_nxt;
	logic        ld_act_nxt, take, start_ld, push;
	logic [7:0]  cm_addr;
	logic [5:0]  cm_idx, cm_ofs;
	logic        cm_we, sm_we;
	logic [12:0] cm_wdata, cm_rdata;
	logic [15:0] wslot_word;
	logic [3:0]  sm_addr;
	logic [27:0] sm_wdata, sm_rdata;

	assign take     = i_frame_valid & o_frame_ready;
	assign start_ld = i_tx_control_slot[ibq_pkg::CS_STB_BIT] & ~stb_prev_r
		& (i_tx_control_slot[ibq_pkg::CS_RAM_HI:ibq_pkg::CS_RAM_LO] != ibq_pkg::RAM_NONE);

	// saturating accumulate of the truncated product
	always_comb begin
		prod  = $signed(cm_rdata[11:0]) * opnd;
		p_now = prod[ibq_pkg::PROD_SHIFT +: ibq_pkg::ACC_W];
		sum   = (st_r == ibq_pkg::ST_ACC2) ? (29'(acc_r) + 29'(p_r)) : (29'(acc_r) + 29'(p_now));
	end

	function automatic logic signed [27:0] sat28(input logic signed [28:0] v);
		if (v > ibq_pkg::ACC_MAX) begin
			return ibq_pkg::ACC_MAX[27:0];
		end else if (v < ibq_pkg::ACC_MIN) begin
			return ibq_pkg::ACC_MIN[27:0];
		end
		return v[27:0];
	endfunction : sat28

	// operand and coefficient address per step
	always_comb begin
		opnd   = xin_r;
		cm_ofs = ibq_pkg::OFS_A;
		if (sec_r != 3'(ibq_pkg::NSEC)) begin
			case (step_r)
				3'h1: begin opnd = w1_r; cm_ofs = ibq_pkg::OFS_D; end
				3'h2: begin opnd = w2_r; cm_ofs = ibq_pkg::OFS_E; end
				3'h3: begin opnd = w1_r; cm_ofs = ibq_pkg::OFS_B; end
				3'h4: begin opnd = w2_r; cm_ofs = ibq_pkg::OFS_C; end
				default: begin opnd = xin_r; cm_ofs = ibq_pkg::OFS_A; end
			endcase
		end
		cm_idx = (sec_r == 3'(ibq_pkg::NSEC)) ? ibq_pkg::F_IDX
			: 6'(6'(sec_r) * ibq_pkg::COEF_STEP) + cm_ofs;
		case (wslot_r)
			2'h1:    wslot_word = s2_r;
			2'h2:    wslot_word = s3_r;
			default: wslot_word = s1_r;
		endcase
		cm_we    = (st_r == ibq_pkg::ST_WR);
		cm_wdata = {wslot_word[ibq_pkg::K_FLAG_BIT],
			wslot_word[ibq_pkg::K_BASE_HI:ibq_pkg::K_BASE_LO]};
		cm_addr  = cm_we ? {ld_ram_r, ld_cnt_r} : {ibq_pkg::RAM_TX, cm_idx};
		sm_we    = (st_r == ibq_pkg::ST_CLR) || (st_r == ibq_pkg::ST_WB1)
			|| (st_r == ibq_pkg::ST_WB2);
		sm_addr  = (st_r == ibq_pkg::ST_CLR) ? clr_r
			: {sec_r, (st_r == ibq_pkg::ST_LDW2) || (st_r == ibq_pkg::ST_WB2)};
		case (st_r)
			ibq_pkg::ST_WB1: sm_wdata = w0_r;
			ibq_pkg::ST_WB2: sm_wdata = w1_r;
			default:         sm_wdata = 28'h0000000;
		endcase
	end

	ibq_mem #(.W(ibq_pkg::COEF_W), .AW(8)) u_coef_ram (
		.i_clk   (i_clk),
		.i_we    (cm_we),
		.i_addr  (cm_addr),
		.i_wdata (cm_wdata),
		.o_rdata (cm_rdata)
	);

	ibq_mem #(.W(ibq_pkg::ACC_W), .AW(4)) u_state_ram (
		.i_clk   (i_clk),
		.i_we    (sm_we),
		.i_addr  (sm_addr),
		.i_wdata (sm_wdata),
		.o_rdata (sm_rdata)
	);

	// frame handling, loading and filter sequencing
	always_comb begin
		st_nxt = st_r; sec_nxt = sec_r; step_nxt = step_r; clr_nxt = clr_r;
		ld_ram_nxt = ld_ram_r; wslot_nxt = wslot_r; ld_cnt_nxt = ld_cnt_r;
		ld_act_nxt = o_load_active; loaded_nxt = o_ram_loaded; stb_prev_nxt = stb_prev_r;
		s1_nxt = s1_r; s2_nxt = s2_r; s3_nxt = s3_r; xin_nxt = xin_r;
		w0_nxt = w0_r; w1_nxt = w1_r; w2_nxt = w2_r; acc_nxt = acc_r; p_nxt = p_r;
		push = 1'b0;
		case (st_r)
			ibq_pkg::ST_CLR: begin
				clr_nxt = clr_r + 4'h1;
				if (clr_r == ibq_pkg::STATE_LAST) st_nxt = ibq_pkg::ST_IDLE;
			end
			ibq_pkg::ST_IDLE: if (take) begin
				s1_nxt = i_tx_slot_one; s2_nxt = i_tx_slot_two; s3_nxt = i_tx_slot_three;
				stb_prev_nxt = i_tx_control_slot[ibq_pkg::CS_STB_BIT];
				if (i_tx_control_slot[ibq_pkg::CS_MODE_BIT]) begin
					if (start_ld) begin
						ld_act_nxt = 1'b1;
						ld_ram_nxt = i_tx_control_slot[ibq_pkg::CS_RAM_HI:ibq_pkg::CS_RAM_LO];
						ld_cnt_nxt = 6'h00;
						wslot_nxt  = 2'h1;
						st_nxt     = ibq_pkg::ST_WR;
					end else if (o_load_active) begin
						wslot_nxt = 2'h0;
						st_nxt    = ibq_pkg::ST_WR;
					end
				end else begin
					xin_nxt  = {i_tx_slot_one, 12'h000};
					sec_nxt  = 3'h0;
					st_nxt   = ibq_pkg::ST_LDW1;
				end
			end
			ibq_pkg::ST_WR: begin
				ld_cnt_nxt = ld_cnt_r + 6'h01;
				wslot_nxt  = wslot_r + 2'h1;
				if (ld_cnt_r == ibq_pkg::LAST_WORD) begin
					ld_act_nxt = 1'b0;
					loaded_nxt[ld_ram_r] = 1'b1;
					st_nxt = ibq_pkg::ST_IDLE;
				end else if (wslot_r == 2'h2) begin
					st_nxt = ibq_pkg::ST_IDLE;
				end
			end
			ibq_pkg::ST_LDW1: st_nxt = ibq_pkg::ST_LDW2;
			ibq_pkg::ST_LDW2: begin
				w1_nxt = sm_rdata;
				st_nxt = ibq_pkg::ST_LDW3;
			end
			ibq_pkg::ST_LDW3: begin
				w2_nxt = sm_rdata; step_nxt = 3'h0; acc_nxt = 28'h0000000;
				st_nxt = ibq_pkg::ST_MAC;
			end
			ibq_pkg::ST_MAC: st_nxt = ibq_pkg::ST_ACC1;
			ibq_pkg::ST_ACC1: begin
				acc_nxt = sat28(sum);
				p_nxt   = p_now;
				st_nxt  = cm_rdata[12] ? ibq_pkg::ST_ACC2 : ibq_pkg::ST_ADV;
			end
			ibq_pkg::ST_ACC2: begin
				acc_nxt = sat28(sum);
				st_nxt  = ibq_pkg::ST_ADV;
			end
			ibq_pkg::ST_ADV: begin
				if (sec_r == 3'(ibq_pkg::NSEC)) begin
					push   = 1'b1;
					st_nxt = ibq_pkg::ST_IDLE;
				end else if (step_r == 3'h2) begin
					w0_nxt = acc_r; step_nxt = 3'h3; st_nxt = ibq_pkg::ST_MAC;
				end else if (step_r == 3'h4) begin
					xin_nxt = acc_r; st_nxt = ibq_pkg::ST_WB1;
				end else begin
					step_nxt = step_r + 3'h1; st_nxt = ibq_pkg::ST_MAC;
				end
			end
			ibq_pkg::ST_WB1: st_nxt = ibq_pkg::ST_WB2;
			ibq_pkg::ST_WB2: begin
				sec_nxt = sec_r + 3'h1;
				if (sec_r == 3'(ibq_pkg::NSEC - 1)) begin
					acc_nxt = 28'h0000000; st_nxt = ibq_pkg::ST_MAC;
				end else begin
					st_nxt = ibq_pkg::ST_LDW1;
				end
			end
			default: st_nxt = ibq_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= ibq_pkg::ST_CLR; sec_r <= 3'h0; step_r <= 3'h0; clr_r <= 4'h0;
			ld_ram_r <= ibq_pkg::RAM_TX; wslot_r <= 2'h0; ld_cnt_r <= 6'h00;
			o_load_active <= 1'b0; o_ram_loaded <= 3'h0; stb_prev_r <= 1'b0;
			s1_r <= 16'h0000; s2_r <= 16'h0000; s3_r <= 16'h0000; xin_r <= 28'h0000000;
			w0_r <= 28'h0000000; w1_r <= 28'h0000000; w2_r <= 28'h0000000;
			acc_r <= 28'h0000000; p_r <= 28'h0000000;
		end else begin
			st_r <= st_nxt; sec_r <= sec_nxt; step_r <= step_nxt; clr_r <= clr_nxt;
			ld_ram_r <= ld_ram_nxt; wslot_r <= wslot_nxt; ld_cnt_r <= ld_cnt_nxt;
			o_load_active <= ld_act_nxt; o_ram_loaded <= loaded_nxt; stb_prev_r <= stb_prev_nxt;
			s1_r <= s1_nxt; s2_r <= s2_nxt; s3_r <= s3_nxt; xin_r <= xin_nxt;
			w0_r <= w0_nxt; w1_r <= w1_nxt; w2_r <= w2_nxt; acc_r <= acc_nxt; p_r <= p_nxt;
		end
	end

	// two-entry output buffer and frame back-pressure
	logic [15:0] b0_nxt, b1_r, b1_nxt;
	logic [1:0]  bcnt_r, bcnt_nxt;
	logic        pop, rdy_nxt;
	always_comb begin
		pop = o_out_valid & i_out_ready;
		b0_nxt = o_out_data; b1_nxt = b1_r; bcnt_nxt = bcnt_r;
		if (pop && !push) begin
			b0_nxt = b1_r; bcnt_nxt = bcnt_r - 2'h1;
		end else if (push && !pop) begin
			if (bcnt_r == 2'h0) b0_nxt = acc_r[27:12]; else b1_nxt = acc_r[27:12];
			bcnt_nxt = bcnt_r + 2'h1;
		end else if (push && pop) begin
			if (bcnt_r == 2'h1) begin
				b0_nxt = acc_r[27:12];
			end else begin
				b0_nxt = b1_r; b1_nxt = acc_r[27:12];
			end
		end
		rdy_nxt = (st_nxt == ibq_pkg::ST_IDLE) && (bcnt_nxt != ibq_pkg::BUF_FULL);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_out_data <= 16'h0000; b1_r <= 16'h0000; bcnt_r <= 2'h0;
			o_out_valid <= 1'b0; o_frame_ready <= 1'b0;
		end else begin
			o_out_data <= b0_nxt; b1_r <= b1_nxt; bcnt_r <= bcnt_nxt;
			o_out_valid <= (bcnt_nxt != 2'h0); o_frame_ready <= rdy_nxt;
		end
	end

	// control slot fields and strap pins
	logic        mode_nxt, clk_nxt, dual_nxt;
	logic [7:0]  bclk_nxt, srate_nxt, att_nxt, comp_nxt, ratio_nxt;
	logic [7:0]  dfield;
	always_comb begin
		dfield = i_tx_control_slot[ibq_pkg::CS_DATA_HI:0];
		mode_nxt = o_coef_load_mode_flag; clk_nxt = o_master_clock_select;
		bclk_nxt = o_tx_bitclock_reg; srate_nxt = o_tx_samplerate_reg;
		att_nxt = o_tx_atten_reg; comp_nxt = o_tx_compensation_reg;
		if (take) begin
			mode_nxt = i_tx_control_slot[ibq_pkg::CS_MODE_BIT];
			clk_nxt  = i_tx_control_slot[ibq_pkg::CS_CLK_BIT];
			case (i_tx_control_slot[ibq_pkg::CS_REG_HI:ibq_pkg::CS_REG_LO])
				ibq_pkg::REG_BITCLK: bclk_nxt  = dfield;
				ibq_pkg::REG_SRATE:  srate_nxt = dfield;
				ibq_pkg::REG_ATTEN:  att_nxt   = dfield;
				ibq_pkg::REG_COMP:   comp_nxt  = dfield;
				default: ;
			endcase
		end
		dual_nxt  = i_serial_mode_pin;
		ratio_nxt = i_frame_rate_pin ? ibq_pkg::RATIO_HI : ibq_pkg::RATIO_LO;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_coef_load_mode_flag <= 1'b0; o_master_clock_select <= 1'b0;
			o_tx_bitclock_reg <= ibq_pkg::CFG_RST; o_tx_samplerate_reg <= ibq_pkg::CFG_RST;
			o_tx_atten_reg <= ibq_pkg::CFG_RST; o_tx_compensation_reg <= ibq_pkg::CFG_RST;
			o_dual_serial_mode <= 1'b0; o_frame_ratio <= ibq_pkg::RATIO_LO;
		end else begin
			o_coef_load_mode_flag <= mode_nxt; o_master_clock_select <= clk_nxt;
			o_tx_bitclock_reg <= bclk_nxt; o_tx_samplerate_reg <= srate_nxt;
			o_tx_atten_reg <= att_nxt; o_tx_compensation_reg <= comp_nxt;
			o_dual_serial_mode <= dual_nxt; o_frame_ratio <= ratio_nxt;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence load_start_s;
		take && i_tx_control_slot[15] && start_ld;
	endsequence
	sequence data_take_s;
		take && !i_tx_control_slot[15];
	endsequence

	sat_high_a: assert property ((st_r == ibq_pkg::ST_ACC1) && (sum > ibq_pkg::ACC_MAX)
		|=> acc_r == 28'h7ffffff) else $error("accumulator not clamped high");
	sat_low_a: assert property ((st_r == ibq_pkg::ST_ACC1) && (sum < ibq_pkg::ACC_MIN)
		|=> acc_r == 28'h8000000) else $error("accumulator not clamped low");
	double_add_a: assert property ((st_r == ibq_pkg::ST_ACC1) && cm_rdata[12]
		|=> (st_r == ibq_pkg::ST_ACC2) ##1 (st_r == ibq_pkg::ST_ADV))
		else $error("doubling flag did not add twice");
	single_add_a: assert property ((st_r == ibq_pkg::ST_ACC1) && !cm_rdata[12]
		|=> st_r == ibq_pkg::ST_ADV) else $error("extra accumulation without flag");
	load_start_a: assert property (load_start_s
		|=> o_load_active && (ld_cnt_r == 6'h00) && (wslot_r == 2'h1))
		else $error("load did not start at word one");
	load_end_a: assert property ((st_r == ibq_pkg::ST_WR) && (ld_cnt_r == 6'h25)
		|=> !o_load_active && o_ram_loaded[$past(ld_ram_r)])
		else $error("load not closed after word 38");
	clk_select_a: assert property (take |=> o_master_clock_select == $past(i_tx_control_slot[13]))
		else $error("master clock select not taken");
	srate_write_a: assert property (take && (i_tx_control_slot[10:8] == 3'h1)
		|=> o_tx_samplerate_reg == $past(i_tx_control_slot[7:0]))
		else $error("sample rate register not written");
	data_run_a: assert property (data_take_s |-> ##[1:250] push)
		else $error("data frame produced no sample");
	frame_ratio_a: assert property (i_frame_rate_pin |=> o_frame_ratio == 8'ha0)
		else $error("frame ratio not 160");
endmodule : ibq_filter_top

//--- logic/ibq_pkg.sv
package ibq_pkg;
	// biquad cascade geometry
	localparam int NSEC   = 7;
	localparam int NWORDS = 38;
	localparam logic [5:0] F_IDX     = 6'h25;
	localparam logic [5:0] LAST_WORD = 6'h25;
	localparam logic [5:0] COEF_STEP = 6'h05;
	// coefficient offsets inside one section, load order B C A D E
	localparam logic [5:0] OFS_B = 6'h00;
	localparam logic [5:0] OFS_C = 6'h01;
	localparam logic [5:0] OFS_A = 6'h02;
	localparam logic [5:0] OFS_D = 6'h03;
	localparam logic [5:0] OFS_E = 6'h04;
	// coefficient slot layout
	localparam int K_FLAG_BIT = 15;
	localparam int K_BASE_HI  = 14;
	localparam int K_BASE_LO  = 3;
	localparam int COEF_W     = 13;
	// datapath
	localparam int ACC_W      = 28;
	localparam int PROD_SHIFT = 12;
	localparam logic signed [28:0] ACC_MAX = 29'sh07ffffff;
	localparam logic signed [28:0] ACC_MIN = 29'sh18000000;
	// control slot layout
	localparam int CS_MODE_BIT = 15;
	localparam int CS_STB_BIT  = 14;
	localparam int CS_CLK_BIT  = 13;
	localparam int CS_RAM_HI   = 12;
	localparam int CS_RAM_LO   = 11;
	localparam int CS_REG_HI   = 10;
	localparam int CS_REG_LO   = 8;
	localparam int CS_DATA_HI  = 7;
	// ram select codes
	localparam logic [1:0] RAM_TX    = 2'h0;
	localparam logic [1:0] RAM_TWO   = 2'h1;
	localparam logic [1:0] RAM_THREE = 2'h2;
	localparam logic [1:0] RAM_NONE  = 2'h3;
	// control register select codes
	localparam logic [2:0] REG_BITCLK = 3'h0;
	localparam logic [2:0] REG_SRATE  = 3'h1;
	localparam logic [2:0] REG_ATTEN  = 3'h2;
	localparam logic [2:0] REG_COMP   = 3'h3;
	localparam logic [2:0] REG_NONE   = 3'h7;
	// reset values
	localparam logic [7:0] CFG_RST = 8'h00;
	// bit frame ratio codes
	localparam logic [7:0] RATIO_HI = 8'ha0;
	localparam logic [7:0] RATIO_LO = 8'h80;
	localparam logic [3:0] STATE_LAST = 4'hd;
	localparam logic [1:0] BUF_FULL   = 2'h2;
	typedef enum logic [11:0] {
		ST_CLR  = 12'h001,
		ST_IDLE = 12'h002,
		ST_WR   = 12'h004,
		ST_LDW1 = 12'h008,
		ST_LDW2 = 12'h010,
		ST_LDW3 = 12'h020,
		ST_MAC  = 12'h040,
		ST_ACC1 = 12'h080,
		ST_ACC2 = 12'h100,
		ST_ADV  = 12'h200,
		ST_WB1  = 12'h400,
		ST_WB2  = 12'h800
	} ibq_state_t;
endpackage : ibq_pkg

//--- logic/ibq_mem.sv
`timescale 1ns/10ps
module ibq_mem #(
	parameter int W  = 16,
	parameter int AW = 4
) (
	// clock
	input  wire logic          i_clk,
	// single port
	input  wire logic          i_we,
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [W-1:0]  i_wdata,
	output logic      [W-1:0]  o_rdata
);
	logic [W-1:0] mem [0:(2**AW)-1];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule : ibq_mem

//--- tb/ibq_host_model.sv
`timescale 1ns/10ps
module ibq_host_model (
	// clock
	input  wire logic        i_clk,
	// frame handshake
	input  wire logic        i_frame_ready,
	output logic             o_frame_valid,
	output logic [15:0]      o_ctrl,
	output logic [15:0]      o_s1,
	output logic [15:0]      o_s2,
	output logic [15:0]      o_s3
);
	initial begin
		o_frame_valid = 1'b0;
		o_ctrl        = 16'h0000;
		o_s1          = 16'h0000;
		o_s2          = 16'h0000;
		o_s3          = 16'h0000;
	end

	// called just after a falling edge; held until the taking edge
	task automatic send(input logic [15:0] c, input logic [15:0] s1, input logic [15:0] s2,
		input logic [15:0] s3);
		o_frame_valid = 1'b1;
		o_ctrl        = c;
		o_s1          = s1;
		o_s2          = s2;
		o_s3          = s3;
		// ready is registered: its level at this falling edge is the one the next rising edge sees
		while (i_frame_ready !== 1'b1) @(negedge i_clk);
		@(posedge i_clk);
		@(negedge i_clk);
		o_frame_valid = 1'b0;
		// idle slots never show the frame just sent
		o_ctrl        = ~c;
		o_s1          = ~s1;
		o_s2          = ~s2;
		o_s3          = ~s3;
		// one edge passes before the next request raises valid again
		@(negedge i_clk);
	endtask : send

	task automatic load(input logic [1:0] ram, input logic [15:0] w [38]);
		send(16'hbfff, 16'hffff, 16'hffff, 16'hffff);
		send({3'b111, ram, 11'h7ff}, 16'hffff, w[0], w[1]);
		for (int f = 0; f < 12; f++) begin
			send({3'b101, ram, 11'h7ff}, w[3*f+2], w[3*f+3], w[3*f+4]);
		end
	endtask : load
endmodule : ibq_host_model

//--- tb/tb_iir_biquad_coeff_loader.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_iir_biquad_coeff_loader;
	logic        i_clk, i_sys_rst, i_frame_valid, o_frame_ready;
	logic [15:0] i_tx_control_slot, i_tx_slot_one, i_tx_slot_two, i_tx_slot_three;
	logic        i_serial_mode_pin, i_frame_rate_pin, o_out_valid, i_out_ready;
	logic [15:0] o_out_data;
	logic        o_coef_load_mode_flag, o_master_clock_select, o_dual_serial_mode;
	logic [7:0]  o_tx_bitclock_reg, o_tx_samplerate_reg, o_tx_atten_reg, o_tx_compensation_reg;
	logic [7:0]  o_frame_ratio;
	logic        o_load_active;
	logic [2:0]  o_ram_loaded;
	int          mismatches = 0;
	int          num_checks = 0;
	logic        stall;
	logic [15:0] words [38];
	logic [12:0] coef [38];
	longint      w1 [7];
	longint      w2 [7];
	logic [15:0] exp_q [$];
	logic [15:0] exp_w;
	logic [7:0]  exp_reg [4];
	localparam logic [2:0] RSEL [5] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h7};
	localparam logic [7:0] DVAL [3] = '{8'ha4, 8'hf1, 8'h40};

	ibq_filter_top dut (.i_clk, .i_sys_rst, .i_frame_valid, .i_tx_control_slot, .i_tx_slot_one,
		.i_tx_slot_two, .i_tx_slot_three, .o_frame_ready, .i_serial_mode_pin, .i_frame_rate_pin,
		.o_out_data, .o_out_valid, .i_out_ready, .o_coef_load_mode_flag, .o_master_clock_select,
		.o_tx_bitclock_reg, .o_tx_samplerate_reg, .o_tx_atten_reg, .o_tx_compensation_reg,
		.o_dual_serial_mode, .o_frame_ratio, .o_load_active, .o_ram_loaded);
	ibq_host_model host (.i_clk, .i_frame_ready(o_frame_ready), .o_frame_valid(i_frame_valid),
		.o_ctrl(i_tx_control_slot), .o_s1(i_tx_slot_one), .o_s2(i_tx_slot_two),
		.o_s3(i_tx_slot_three));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	function automatic longint sat(longint s);
		if (s > 64'sd134217727) return 64'sd134217727;
		if (s < -64'sd134217728) return -64'sd134217728;
		return s;
	endfunction : sat

	function automatic longint mac(longint s, logic [12:0] k, longint x);
		longint p;
		p = (longint'($signed(k[11:0])) * x) >>> 12;
		s = sat(s + p);
		if (k[12]) s = sat(s + p);
		return s;
	endfunction : mac

	function automatic logic [15:0] filt(logic [15:0] smp);
		longint x;
		longint w0;
		longint y;
		longint o;
		x = longint'($signed(smp)) * 4096;
		for (int s = 0; s < 7; s++) begin
			w0 = mac(mac(mac(0, coef[s*5+2], x), coef[s*5+3], w1[s]), coef[s*5+4], w2[s]);
			y = mac(mac(w0, coef[s*5], w1[s]), coef[s*5+1], w2[s]);
			w2[s] = w1[s];
			w1[s] = w0;
			x = y;
		end
		o = mac(0, coef[37], x);
		return o[27:12];
	endfunction : filt

	task automatic cyc(int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc

	task automatic close_out();
		if (mismatches == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic do_reset();
		i_sys_rst = 1'b1;
		cyc(10);
		`CHK({o_frame_ready, o_out_valid, o_load_active, o_ram_loaded, o_coef_load_mode_flag,
			o_master_clock_select}, 8'h00)
		`CHK({o_tx_bitclock_reg, o_tx_samplerate_reg, o_tx_atten_reg, o_tx_compensation_reg}, 32'h0)
		`CHK(o_frame_ratio, 8'h80)
		i_sys_rst = 1'b0;
		foreach (w1[s]) begin
			w1[s] = 0;
			w2[s] = 0;
		end
		exp_reg = '{default: 8'h00};
		// section state clear must finish before the first frame is offered
		cyc(16);
		`CHK(o_frame_ready, 1'b1)
	endtask : do_reset

	task automatic rand_words(bit big);
		foreach (words[i]) words[i] = big ? 16'hbff8 :
			{1'($urandom), 12'($urandom_range(0, 800) - 400), 3'h0};
		words[35] = 16'h0000;
		words[36] = 16'h0000;
		// first section made a plain gain: A one half, the other four zero
		if (!big) for (int i = 0; i < 5; i++) words[i] = (i == 2) ? 16'ha000 : 16'h0000;
	endtask : rand_words

	task automatic load(logic [1:0] ram);
		fork
			host.load(ram, words);
			begin
				cyc(15);
				`CHK(o_load_active, 1'b1)
			end
		join
		cyc(6);
		`CHK(o_load_active, 1'b0)
		`CHK(o_ram_loaded[ram], 1'b1)
		`CHK(o_coef_load_mode_flag, 1'b1)
		if (ram == 2'h0) foreach (coef[i]) coef[i] = words[i][15:3];
	endtask : load

	task automatic data(logic [15:0] smp);
		exp_q.push_back(filt(smp));
		host.send(16'h3fff, smp, ~smp, 16'h5a5a);
	endtask : data

	task automatic drain();
		for (int n = 0; n < 2000 && exp_q.size() != 0; n++) @(negedge i_clk);
		`CHK(exp_q.size(), 0)
	endtask : drain

	always @(negedge i_clk) i_out_ready <= stall ? 1'b0 : 1'($urandom_range(0, 3) != 0);

	always @(posedge i_clk) begin
		if (!i_sys_rst && o_out_valid === 1'b1 && i_out_ready === 1'b1) begin
			// an unexpected word can never match its own inverse
			exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : ~o_out_data;
			`CHK(o_out_data, exp_w)
		end
	end

	initial begin
		#(60000 * 8);
		mismatches++;
		close_out();
	end

	initial begin
		void'($urandom(32'h481ac813));
		i_sys_rst = 1'b1;
		i_serial_mode_pin = 1'b0;
		i_frame_rate_pin = 1'b0;
		stall = 1'b1;
		@(negedge i_clk);
		do_reset();
		for (int p = 0; p < 4; p++) begin
			i_serial_mode_pin = p[0];
			i_frame_rate_pin = p[1];
			cyc(3);
			`CHK(o_dual_serial_mode, p[0])
			`CHK(o_frame_ratio, p[1] ? 8'ha0 : 8'h80)
		end
		i_serial_mode_pin = 1'b0;
		i_frame_rate_pin = 1'b0;
		for (int i = 0; i < 5; i++) begin
			logic [7:0] d;
			d = (i < 3) ? DVAL[i] : 8'($urandom);
			host.send({2'b10, i[0], 2'h3, RSEL[i], d}, 16'hffff, 16'hffff, 16'hffff);
			if (RSEL[i] != 3'h7) exp_reg[RSEL[i][1:0]] = d;
			cyc(1);
			`CHK({o_tx_bitclock_reg, o_tx_samplerate_reg, o_tx_atten_reg, o_tx_compensation_reg},
				{exp_reg[0], exp_reg[1], exp_reg[2], exp_reg[3]})
			`CHK(o_master_clock_select, i[0])
		end
		host.send(16'hdfff, 16'hffff, 16'h1234, 16'h5678);
		cyc(4);
		`CHK(o_load_active, 1'b0)
		for (int r = 2; r >= 0; r--) begin
			rand_words(1'b0);
			load(2'(r));
		end
		`CHK(o_ram_loaded, 3'h7)
		stall = 1'b0;
		repeat (30) data(16'($urandom));
		`CHK(o_coef_load_mode_flag, 1'b0)
		drain();
		stall = 1'b1;
		cyc(1);
		data(16'($urandom));
		data(16'($urandom));
		cyc(400);
		`CHK({o_out_valid, o_frame_ready}, 2'b10)
		stall = 1'b0;
		drain();
		for (int pol = 0; pol < 2; pol++) begin
			do_reset();
			rand_words(1'b1);
			load(2'h0);
			repeat (3) data(pol ? 16'h8000 : 16'h7fff);
			drain();
		end
		close_out();
	end
endmodule : tb_iir_biquad_coeff_loader
